/* pcq_pkg.sv */
// Purpose: Shared constants and types of the pulse counter register block
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes: Offsets are byte addresses
package pcq_pkg;
   // ****************************************************
   // Register offsets
   // ****************************************************
   localparam logic [7:0] OFF_CONTROL = 8'h00;
   localparam logic [7:0] OFF_COMMAND = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;
   localparam logic [7:0] OFF_COUNT = 8'h0c;
   localparam logic [7:0] OFF_RELOAD = 8'h10;
   localparam logic [7:0] OFF_RELOAD_BUF = 8'h14;
   localparam logic [7:0] OFF_FLAGS = 8'h18;
   localparam logic [7:0] OFF_FLAG_SET = 8'h1c;
   localparam logic [7:0] OFF_FLAG_CLEAR = 8'h20;
   localparam logic [7:0] OFF_IRQ_ENABLE = 8'h24;
   localparam logic [7:0] OFF_ROUTING = 8'h28;
   localparam logic [7:0] OFF_FREEZE = 8'h2c;
   localparam logic [7:0] OFF_SYNC_PENDING = 8'h30;
   // ****************************************************
   // Field positions and reset values
   // ****************************************************
   localparam int CTL_HOLD_BIT = 5;
   localparam int CMD_LOAD_RELOAD_BIT = 1;
   localparam int CMD_LOAD_COUNT_BIT = 0;
   localparam int FLAG_UNDER_BIT = 0;
   localparam int FLAG_OVER_BIT = 1;
   localparam int FLAG_DIRCHG_BIT = 2;
   localparam int SYNC_CTL_BIT = 0;
   localparam int SYNC_CMD_BIT = 1;
   localparam int SYNC_BUF_BIT = 2;
   localparam logic [15:0] RELOAD_RESET = 16'h00ff;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam int FILTER_CYCLES = 5;
   localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

   // Mode field encoding
   typedef enum logic [1:0] {
      MODE_DISABLED = 2'h0,
      MODE_OVERSAMPLED_SINGLE = 2'h1,
      MODE_PIN_CLOCKED_SINGLE = 2'h2,
      MODE_PIN_CLOCKED_QUAD = 2'h3
   } pcq_mode_type;

   // Control register fields
   typedef struct packed {
      logic domain_reset_hold;
      logic width_filter_on;
      logic falling_select;
      logic count_direction;
      pcq_mode_type mode;
   } pcq_control_type;
endpackage

/* pcq_sync.sv */
// Purpose: Two-flop synchroniser for one level
// Assumes: Input is asynchronous to mclk_in
// Notes: Stage one is read only by stage two
`timescale 1ns/10ps
module pcq_sync (
   // Clock and control
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic ce_in,
   // Data
   input wire logic async_in,
   output logic sync_out
);
   logic stage1;
   logic next_stage1;
   logic next_sync;

   // Shift one place per enabled clock
   always_comb begin
      next_stage1 = ce_in ? async_in : stage1;
      next_sync = ce_in ? stage1 : sync_out;
   end

   // Plain registers
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         stage1 <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         stage1 <= next_stage1;
         sync_out <= next_sync;
      end
   end
endmodule

/* pcq_filter.sv */
// Purpose: Pulse width filter for the sampled first input
// Assumes: One sample per enabled sampling tick
// Notes: Bypassed when not enabled
`timescale 1ns/10ps
module pcq_filter #(
   parameter int CYCLES = 5
) (
   // Clock and control
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic ce_in,
   input wire logic tick_in,
   input wire logic enable_in,
   // Data
   input wire logic level_in,
   output logic level_out
);
   logic [3:0] run;
   logic [3:0] next_run;
   logic held;
   logic next_held;

   // Accept a new level only after it stood CYCLES ticks
   always_comb begin
      next_run = run;
      next_held = held;
      if (ce_in && tick_in) begin
         if (!enable_in) begin
            next_held = level_in;
            next_run = 4'h0;
         end else if (level_in == held) begin
            next_run = 4'h0;
         end else if (run == 4'(CYCLES - 1)) begin
            next_held = level_in; // see RULE5
            next_run = 4'h0;
         end else begin
            next_run = run + 4'h1;
         end
      end
      level_out = held;
   end

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         run <= 4'h0;
         held <= 1'b0;
      end else begin
         run <= next_run;
         held <= next_held;
      end
   end
endmodule

/* pcq_top.sv */
// Purpose: Pulse counter with quadrature decoding behind an APB slave
// Assumes: Pins and the low-frequency tick arrive asynchronously
// Notes: Pin edges are found by sampling with mclk_in
// Operation
// RULE1 - Mode field selects off, oversampled, pin, quadrature
// RULE2 - Modes 2 and 3 count on pin edges
// RULE3 - Software picks the matching counter clock source
// RULE4 - Hold bit resets counter domain, release two edges
// RULE5 - Filter needs five stable samples, oversampled only
// RULE6 - Oversampled mode counts rising or falling edges
// RULE7 - Edge select inverts quadrature direction only
// RULE8 - Change edge select only while disabled
// RULE9 - Direction bit used in single modes only
// RULE10 - Command bit one loads buffer into reload
// RULE11 - Command strobes cross into counter domain
// RULE12 - Flag set and clear registers, flags read-only
// RULE13 - Reload read-only, buffer register read-write
// RULE14 - Software writes zeros to reserved bits
// RULE15 - Thirteen word registers decoded
// RULE16 - Control writes synchronised before affecting counting
// RULE17 - Up past reload sets overflow, count zero
// RULE18 - Down past zero sets underflow, load reload
// RULE19 - Quadrature samples second input on both edges
// RULE20 - Pin clock needs pulses before updates apply
// RULE21 - Command bit zero reloads the count
// RULE22 - Sync pending shows transfers not yet complete
//
// Implementation choice: the APB slave port.
`timescale 1ns/10ps
module pcq_top #(
   parameter int COUNT_W = 16
) (
   // Clock, reset, enable
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic ce_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Pins and sampling tick
   input wire logic first_input_pin_in,
   input wire logic second_input_pin_in,
   input wire logic low_freq_clock_in,
   // Status
   output logic [COUNT_W-1:0] count_value_out
);
   // ****************************************************
   // Input synchronisers
   // ****************************************************
   logic s0;
   logic s1;
   logic lfc;
   pcq_sync u_sync_s0 (.mclk_in(mclk_in), .resetn_in(resetn_in), .ce_in(ce_in),
      .async_in(first_input_pin_in), .sync_out(s0));
   pcq_sync u_sync_s1 (.mclk_in(mclk_in), .resetn_in(resetn_in), .ce_in(ce_in),
      .async_in(second_input_pin_in), .sync_out(s1));
   pcq_sync u_sync_lf (.mclk_in(mclk_in), .resetn_in(resetn_in), .ce_in(ce_in),
      .async_in(low_freq_clock_in), .sync_out(lfc));

   // ****************************************************
   // Bus-side registers
   // ****************************************************
   pcq_pkg::pcq_control_type ctl;
   pcq_pkg::pcq_control_type next_ctl;
   logic [COUNT_W-1:0] buf_reg;
   logic [COUNT_W-1:0] next_buf_reg;
   logic [2:0] ien;
   logic [2:0] next_ien;
   logic [31:0] route;
   logic [31:0] next_route;
   logic freeze;
   logic next_freeze;
   logic [1:0] cmd_pend;
   logic [1:0] next_cmd_pend;
   logic [2:0] busy;
   logic [2:0] next_busy;
   logic [2:0] set_req;
   logic [2:0] clr_req;
   logic wr;
   logic rd;

   // Write lands only at the edge that ends the transfer, so set and clear act once
   // Read data is registered in the first access cycle, ready when pready is seen
   always_comb begin
      wr = psel_in && penable_in && pready_out && pwrite_in && ce_in;
      rd = psel_in && penable_in && !pready_out && !pwrite_in && ce_in;
   end

   // ****************************************************
   // Counter domain state
   // ****************************************************
   pcq_pkg::pcq_control_type cctl;
   pcq_pkg::pcq_control_type next_cctl;
   logic [COUNT_W-1:0] cnt;
   logic [COUNT_W-1:0] next_cnt;
   logic [COUNT_W-1:0] top;
   logic [COUNT_W-1:0] next_top;
   logic [2:0] flags;
   logic [2:0] next_flags;
   logic dir;
   logic next_dir;
   logic [1:0] hold_pipe;
   logic [1:0] next_hold_pipe;
   logic dom_rst;
   logic s0_prev;
   logic next_s0_prev;
   logic s1_pos;
   logic next_s1_pos;
   logic lfc_prev;
   logic width_filter_on_prev;
   logic next_width_filter_on_prev;
   logic width_filter_on_lvl;
   logic tick;
   logic pulse;
   logic down;
   logic sample_edge;

   // Sampling tick from the slow clock rising edge
   always_comb tick = lfc && !lfc_prev;

   pcq_filter #(.CYCLES(pcq_pkg::FILTER_CYCLES)) u_filter (
      .mclk_in(mclk_in), .resetn_in(resetn_in), .ce_in(ce_in), .tick_in(tick),
      .enable_in(cctl.width_filter_on), .level_in(s0), .level_out(width_filter_on_lvl)); // see RULE5

   // Domain reset: bit held, then released after two counter edges
   always_comb begin
      next_hold_pipe = hold_pipe;
      if (ctl.domain_reset_hold) begin
         next_hold_pipe = 2'b11; // see RULE4
      end else if (sample_edge) begin
         next_hold_pipe = {hold_pipe[0], 1'b0};
      end
      dom_rst = ctl.domain_reset_hold || hold_pipe[1];
   end

   // Counter edge per mode: oversampled tick or a rising pin edge
   always_comb begin
      sample_edge = tick;
      if (cctl.mode == pcq_pkg::MODE_PIN_CLOCKED_SINGLE || cctl.mode == pcq_pkg::MODE_PIN_CLOCKED_QUAD) begin
         sample_edge = s0 && !s0_prev; // see RULE2
      end
   end

   // Pulse and direction decode
   always_comb begin
      pulse = 1'b0;
      next_dir = dir;
      next_s1_pos = s1_pos;
      down = cctl.count_direction; // see RULE9
      case (cctl.mode)
         pcq_pkg::MODE_OVERSAMPLED_SINGLE: begin
            if (tick) begin
               // Rising or falling edge of the filtered level
               pulse = cctl.falling_select ? (width_filter_on_prev && !width_filter_on_lvl) : (!width_filter_on_prev && width_filter_on_lvl); // see RULE6
            end
         end
         pcq_pkg::MODE_PIN_CLOCKED_SINGLE: begin
            pulse = s0 && !s0_prev; // see RULE7
         end
         pcq_pkg::MODE_PIN_CLOCKED_QUAD: begin
            if (s0 && !s0_prev) begin
               next_s1_pos = s1; // see RULE19
            end else if (!s0 && s0_prev) begin
               // Count only when the two samples differ
               pulse = s1_pos != s1; // see RULE19
               if (pulse) begin
                  next_dir = s1_pos ^ cctl.falling_select; // see RULE7
               end
            end
            down = next_dir;
         end
         default: begin
            pulse = 1'b0; // see RULE1
         end
      endcase
   end

   // Count, reload, flags and synchronised control
   always_comb begin
      next_cctl = ctl; // see RULE16
      next_cnt = cnt;
      next_top = top;
      next_flags = (flags | set_req) & ~clr_req; // see RULE12
      next_cmd_pend = cmd_pend;
      next_busy = busy;
      next_width_filter_on_prev = tick ? width_filter_on_lvl : width_filter_on_prev;
      next_s0_prev = s0;
      if (pulse) begin
         if (!down) begin
            if (cnt == top) begin
               next_cnt = '0; // see RULE17
               next_flags[pcq_pkg::FLAG_OVER_BIT] = 1'b1;
            end else begin
               next_cnt = cnt + 1'b1;
            end
         end else if (cnt == '0) begin
            next_cnt = top; // see RULE18
            next_flags[pcq_pkg::FLAG_UNDER_BIT] = 1'b1;
         end else begin
            next_cnt = cnt - 1'b1;
         end
      end
      if (cctl.mode == pcq_pkg::MODE_PIN_CLOCKED_QUAD && next_dir != dir) begin
         next_flags[pcq_pkg::FLAG_DIRCHG_BIT] = 1'b1;
      end
      // Strobes take effect on the next counter edge, or on the next clock while disabled
      if (sample_edge || cctl.mode == pcq_pkg::MODE_DISABLED) begin
         if (cmd_pend[pcq_pkg::CMD_LOAD_RELOAD_BIT]) begin
            next_top = buf_reg; // see RULE10
         end
         if (cmd_pend[pcq_pkg::CMD_LOAD_COUNT_BIT]) begin
            next_cnt = pcq_pkg::COUNT_RESET; // see RULE21
         end
         next_cmd_pend = 2'b00; // see RULE11
         next_busy = 3'b000; // see RULE22
      end
      if (wr && paddr_in == pcq_pkg::OFF_COMMAND) begin
         next_cmd_pend = cmd_pend | pwdata_in[1:0]; // see RULE11
         next_busy[pcq_pkg::SYNC_CMD_BIT] = |pwdata_in[1:0];
      end
      if (wr && paddr_in == pcq_pkg::OFF_CONTROL) begin
         next_busy[pcq_pkg::SYNC_CTL_BIT] = 1'b1; // see RULE22
      end
      if (wr && paddr_in == pcq_pkg::OFF_RELOAD_BUF) begin
         next_busy[pcq_pkg::SYNC_BUF_BIT] = 1'b1;
      end
   end

   // ****************************************************
   // Register writes
   // ****************************************************
   always_comb begin
      next_ctl = ctl;
      next_buf_reg = buf_reg;
      next_ien = ien;
      next_route = route;
      next_freeze = freeze;
      set_req = 3'b000;
      clr_req = 3'b000;
      if (wr) begin
         case (paddr_in)
            pcq_pkg::OFF_CONTROL: next_ctl = pcq_pkg::pcq_control_type'(pwdata_in[5:0]); // see RULE15
            pcq_pkg::OFF_RELOAD_BUF: next_buf_reg = pwdata_in[COUNT_W-1:0]; // see RULE13
            pcq_pkg::OFF_FLAG_SET: set_req = pwdata_in[2:0]; // see RULE12
            pcq_pkg::OFF_FLAG_CLEAR: clr_req = pwdata_in[2:0]; // see RULE12
            pcq_pkg::OFF_IRQ_ENABLE: next_ien = pwdata_in[2:0];
            pcq_pkg::OFF_ROUTING: next_route = pwdata_in;
            pcq_pkg::OFF_FREEZE: next_freeze = pwdata_in[0];
            default: next_ctl = ctl;
         endcase
      end
   end

   // Read mux, sampled in the first access cycle
   logic [31:0] next_rdata;
   always_comb begin
      case (paddr_in)
         pcq_pkg::OFF_CONTROL: next_rdata = {26'h0, ctl};
         pcq_pkg::OFF_STATUS: next_rdata = {31'h0, dir};
         pcq_pkg::OFF_COUNT: next_rdata = 32'(cnt);
         pcq_pkg::OFF_RELOAD: next_rdata = 32'(top); // see RULE13
         pcq_pkg::OFF_RELOAD_BUF: next_rdata = 32'(buf_reg);
         pcq_pkg::OFF_FLAGS: next_rdata = {29'h0, flags};
         pcq_pkg::OFF_IRQ_ENABLE: next_rdata = {29'h0, ien};
         pcq_pkg::OFF_ROUTING: next_rdata = route;
         pcq_pkg::OFF_FREEZE: next_rdata = {31'h0, freeze};
         pcq_pkg::OFF_SYNC_PENDING: next_rdata = {29'h0, busy}; // see RULE22
         default: next_rdata = pcq_pkg::UNMAPPED_READ;
      endcase
   end

   // ****************************************************
   // Registers
   // ****************************************************
   // Domain reset wins over everything in the counter state
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         ctl <= '0;
         buf_reg <= pcq_pkg::RELOAD_RESET;
         ien <= 3'h0;
         route <= 32'h0000_0000;
         freeze <= 1'b0;
         hold_pipe <= 2'b00;
         lfc_prev <= 1'b0;
         prdata_out <= 32'h0000_0000;
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
         count_value_out <= '0;
         cmd_pend <= 2'b00;
         busy <= 3'b000;
      end else if (ce_in) begin
         ctl <= next_ctl;
         buf_reg <= next_buf_reg;
         ien <= next_ien;
         route <= next_route;
         freeze <= next_freeze;
         hold_pipe <= next_hold_pipe;
         lfc_prev <= lfc;
         prdata_out <= rd ? next_rdata : prdata_out;
         pready_out <= psel_in && penable_in && !pready_out;
         pslverr_out <= 1'b0;
         count_value_out <= next_cnt;
         cmd_pend <= next_cmd_pend;
         busy <= next_busy;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!resetn_in || (ce_in && dom_rst)) begin
         cctl <= '0; // see RULE4
         cnt <= pcq_pkg::COUNT_RESET;
         top <= pcq_pkg::RELOAD_RESET;
         flags <= 3'h0;
         dir <= 1'b0;
         s0_prev <= 1'b0;
         s1_pos <= 1'b0;
         width_filter_on_prev <= 1'b0;
      end else if (ce_in) begin
         cctl <= next_cctl;
         cnt <= next_cnt;
         top <= next_top;
         flags <= next_flags;
         dir <= next_dir;
         s0_prev <= next_s0_prev;
         s1_pos <= next_s1_pos;
         width_filter_on_prev <= next_width_filter_on_prev;
      end
   end

   // ****************************************************
   // Assertions
   // ****************************************************
   property p_overflow;
      @(posedge mclk_in) disable iff (!resetn_in || dom_rst)
      (ce_in && pulse && !down && cnt == top) |=> (cnt == '0 && flags[pcq_pkg::FLAG_OVER_BIT]);
   endproperty
   a_overflow: assert property (p_overflow) else $error("overflow not taken"); // see RULE17

   property p_underflow;
      @(posedge mclk_in) disable iff (!resetn_in || dom_rst)
      (ce_in && pulse && down && cnt == '0 && !(sample_edge && cmd_pend[pcq_pkg::CMD_LOAD_COUNT_BIT]))
         |=> (cnt == $past(top) && flags[pcq_pkg::FLAG_UNDER_BIT]);
   endproperty
   a_underflow: assert property (p_underflow) else $error("underflow not taken"); // see RULE18

   property p_hold;
      @(posedge mclk_in) disable iff (!resetn_in)
      (ce_in && ctl.domain_reset_hold) |=> (cnt == pcq_pkg::COUNT_RESET && top == pcq_pkg::RELOAD_RESET);
   endproperty
   a_hold: assert property (p_hold) else $error("domain not held in reset"); // see RULE4

   property p_disabled;
      @(posedge mclk_in) disable iff (!resetn_in)
      (cctl.mode == pcq_pkg::MODE_DISABLED) |-> !pulse;
   endproperty
   a_disabled: assert property (p_disabled) else $error("pulse while disabled"); // see RULE1

   property p_flag_set;
      @(posedge mclk_in) disable iff (!resetn_in || dom_rst)
      (ce_in && wr && paddr_in == pcq_pkg::OFF_FLAG_SET && pwdata_in[0]) |=> flags[0];
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag set ignored"); // see RULE12

   property p_reload_load;
      @(posedge mclk_in) disable iff (!resetn_in || dom_rst)
      (ce_in && cmd_pend[1] && cctl.mode == pcq_pkg::MODE_DISABLED) |=> (top == $past(buf_reg));
   endproperty
   a_reload_load: assert property (p_reload_load) else $error("reload not loaded"); // see RULE10

   property p_count_load;
      @(posedge mclk_in) disable iff (!resetn_in || dom_rst)
      (ce_in && cmd_pend[0] && cctl.mode == pcq_pkg::MODE_DISABLED) |=> (cnt == pcq_pkg::COUNT_RESET);
   endproperty
   a_count_load: assert property (p_count_load) else $error("count not loaded"); // see RULE21

   property p_busy;
      @(posedge mclk_in) disable iff (!resetn_in)
      (ce_in && wr && paddr_in == pcq_pkg::OFF_CONTROL) |=> busy[pcq_pkg::SYNC_CTL_BIT];
   endproperty
   a_busy: assert property (p_busy) else $error("sync pending not raised"); // see RULE22

   property p_ctl_sync;
      @(posedge mclk_in) disable iff (!resetn_in || dom_rst)
      (ce_in && !dom_rst) ##1 ce_in |-> cctl == $past(ctl);
   endproperty
   a_ctl_sync: assert property (p_ctl_sync) else $error("control not carried"); // see RULE16
endmodule

/* pcq_pin_model.sv */
// Purpose: Pin-side model of a pulse sensor or quadrature shaft encoder
// Assumes: Push-pull outputs that hold their level between bursts
// Notes: Bursts are started by task calls from the bench
`timescale 1ns/10ps
module pcq_pin_model (
   // Pins towards the counter
   output logic first_out,
   output logic second_out
);
   // ****************************************************
   // Idle level
   // ****************************************************
   // Both phases rest low, no release: the sensor drives its pins
   initial begin
      first_out = 1'b0;
      second_out = 1'b0;
   end

   // ****************************************************
   // Stimulus tasks
   // ****************************************************
   // Single level step, used to see which edge is counted
   task automatic level(input logic v);
      first_out = v;
   endtask

   // Pulse trains; quadrature phases a quarter period apart
   task automatic burst(input int n, input int half, input bit quad, input bit lead, input bit glitch);
      for (int i = 0; i < n; i++) begin
         if (quad && !lead) begin
            first_out = 1'b1;
            #(half) second_out = 1'b1;
            #(half) first_out = 1'b0;
            #(half) second_out = 1'b0;
            #(half);
         end else if (quad) begin
            second_out = 1'b1;
            #(half) first_out = 1'b1;
            #(half) second_out = 1'b0;
            #(half) first_out = 1'b0;
            #(half);
         end else begin
            first_out = 1'b1;
            #(half) first_out = 1'b0;
            #(half);
            // Short spike that a width filter has to swallow
            if (glitch) begin
               first_out = 1'b1;
               #(half / 3) first_out = 1'b0;
               #(half);
            end
         end
      end
   endtask
endmodule

/* test_pulse_counter_quadrature_regs.sv */
// Purpose: Self-checking bench of the pulse counter register block
// Assumes: Design answers APB with one wait state at most a few cycles
// Notes: Counts are checked relative to the value before each burst
`timescale 1ns/10ps
module test_pulse_counter_quadrature_regs;
   logic mclk_in, resetn_in, psel_in, penable_in, pwrite_in, lf_clk, pin_a, pin_b;
   logic pready_out, pslverr_out;
   logic [7:0] paddr_in;
   logic [31:0] pwdata_in, prdata_out, rd;
   logic [15:0] count_value_out, top;
   logic [1:0] fl;
   int errors, compares;

   // ****************************************************
   // Clocks, design and pin model
   // ****************************************************
   // Sampling tick at 64 ns, its edges fall on bus clock falling edges
   always #4 mclk_in = !mclk_in;
   always #32 lf_clk = !lf_clk;

   pcq_top dut (.mclk_in(mclk_in), .resetn_in(resetn_in), .ce_in(1'b1), .psel_in(psel_in),
      .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
      .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
      .first_input_pin_in(pin_a), .second_input_pin_in(pin_b), .low_freq_clock_in(lf_clk),
      .count_value_out(count_value_out));
   pcq_pin_model pins (.first_out(pin_a), .second_out(pin_b));

   // ****************************************************
   // Shared tasks
   // ****************************************************
   task check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task give_verdict;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // One APB transfer; request held until pready is seen at an edge
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk_in);
      psel_in <= 1'b1;
      pwrite_in <= wr;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge mclk_in);
      penable_in <= 1'b1;
      n = 0;
      @(posedge mclk_in);
      while (pready_out !== 1'b1 && n < 40) begin
         @(posedge mclk_in);
         n++;
      end
      if (n >= 40) errors++;
      rd = prdata_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask

   task rd_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rd, exp);
      check({31'h0, pslverr_out}, 32'h0);
   endtask

   // Expected count after n pulses, wrapping at top and at zero
   function automatic logic [15:0] step(input logic [15:0] c, input int n, input bit down);
      for (int i = 0; i < n; i++) begin
         if (!down && c == top) begin
            c = 16'h0;
            fl[1] = 1'b1;
         end else if (down && c == 16'h0) begin
            c = top;
            fl[0] = 1'b1;
         end else begin
            c = down ? c - 16'h1 : c + 16'h1;
         end
      end
      return c;
   endfunction

   // Configure through disabled mode, warm the pin clock, then count
   task run(input logic [5:0] ctl, input int n, input int half, input bit lead, input bit glitch);
      bit quad, down, one;
      logic [15:0] c;
      quad = (ctl[1:0] == 2'h3);
      down = quad ? (lead ^ ctl[3]) : ctl[2];
      one = (ctl[1:0] == 2'h1);
      apb(1'b1, pcq_pkg::OFF_CONTROL, {26'h0, ctl[5:2], 2'h0});
      apb(1'b1, pcq_pkg::OFF_CONTROL, {26'h0, ctl});
      pins.burst(3, half, quad, lead, 1'b0);
      repeat (80) @(posedge mclk_in);
      rd_chk(pcq_pkg::OFF_SYNC_PENDING, 32'h0);
      apb(1'b1, pcq_pkg::OFF_FLAG_CLEAR, 32'h3);
      c = count_value_out;
      fl = 2'h0;
      pins.burst(n, half, quad, lead, glitch);
      repeat (80) @(posedge mclk_in);
      c = step(c, n, down);
      rd_chk(pcq_pkg::OFF_COUNT, {16'h0, c});
      if (quad) rd_chk(pcq_pkg::OFF_STATUS, {31'h0, down});
      pins.level(1'b1);
      repeat (80) @(posedge mclk_in);
      c = step(c, (ctl[1:0] == 2'h2 || (one && !ctl[3])) ? 1 : 0, down);
      check({16'h0, count_value_out}, {16'h0, c});
      pins.level(1'b0);
      repeat (80) @(posedge mclk_in);
      c = step(c, (one && ctl[3]) ? 1 : 0, down);
      check({16'h0, count_value_out}, {16'h0, c});
      apb(1'b0, pcq_pkg::OFF_FLAGS, 32'h0);
      check(rd & 32'h3, {30'h0, fl});
   endtask

   // ****************************************************
   // Main sequence
   // ****************************************************
   initial begin
      mclk_in = 1'b0;
      lf_clk = 1'b0;
      resetn_in = 1'b0;
      psel_in = 1'b0;
      penable_in = 1'b0;
      pwrite_in = 1'b0;
      paddr_in = 8'h0;
      pwdata_in = 32'h0;
      errors = 0;
      compares = 0;
      void'($urandom(80697));
      repeat (16) @(posedge mclk_in);
      resetn_in <= 1'b1;
      rd_chk(pcq_pkg::OFF_CONTROL, 32'h0);
      rd_chk(pcq_pkg::OFF_COUNT, 32'h0);
      rd_chk(pcq_pkg::OFF_RELOAD_BUF, 32'h0000_00ff);
      rd_chk(8'h40, 32'h0);
      top = 16'h4 + 16'($urandom % 6);
      apb(1'b1, pcq_pkg::OFF_RELOAD, 32'h1234);
      rd_chk(pcq_pkg::OFF_RELOAD, 32'h0000_00ff);
      apb(1'b1, pcq_pkg::OFF_RELOAD_BUF, {16'h0, top});
      rd_chk(pcq_pkg::OFF_RELOAD_BUF, {16'h0, top});
      apb(1'b1, pcq_pkg::OFF_COMMAND, 32'h2);
      rd_chk(pcq_pkg::OFF_RELOAD, {16'h0, top});
      // Flag register itself ignores writes
      apb(1'b1, pcq_pkg::OFF_FLAG_SET, 32'h3);
      apb(1'b1, pcq_pkg::OFF_FLAG_CLEAR, 32'h1);
      apb(1'b1, pcq_pkg::OFF_FLAGS, 32'h0);
      rd_chk(pcq_pkg::OFF_FLAGS, 32'h2);
      // Pin clocked, quadrature and oversampled cases
      run(6'h12, 5 + int'($urandom % 8), 32, 1'b0, 1'b0);
      run(6'h0e, 5 + int'($urandom % 8), 32, 1'b0, 1'b0);
      run(6'h11, 5 + int'($urandom % 8), 384, 1'b0, 1'b1);
      run(6'h0d, 5 + int'($urandom % 8), 384, 1'b0, 1'b0);
      run(6'h07, 5 + int'($urandom % 8), 32, 1'b0, 1'b0);
      run(6'h03, 5 + int'($urandom % 8), 32, 1'b1, 1'b0);
      run(6'h0b, 5 + int'($urandom % 8), 32, 1'b0, 1'b0);
      apb(1'b1, pcq_pkg::OFF_CONTROL, 32'h0);
      apb(1'b1, pcq_pkg::OFF_COMMAND, 32'h1);
      rd_chk(pcq_pkg::OFF_COUNT, 32'h0);
      apb(1'b1, pcq_pkg::OFF_CONTROL, 32'h20);
      repeat (20) @(posedge mclk_in);
      rd_chk(pcq_pkg::OFF_RELOAD, 32'h0000_00ff);
      apb(1'b1, pcq_pkg::OFF_CONTROL, 32'h0);
      give_verdict;
   end

   // Watchdog well beyond the longest run of all cases
   initial begin
      #500000;
      errors++;
      give_verdict;
   end
endmodule
